//--- inc/rtc_pkg.sv
// constants for the regulator three control register group
package rtc_pkg;
  // register addresses on the host serial interface
  localparam logic [7:0] ADDR_OPERATING = 8'h16;
  localparam logic [7:0] ADDR_ALTERNATE = 8'h17;
  localparam logic [7:0] ADDR_CEILING   = 8'h18;

  // field layout
  localparam int CODE_MSB      = 5;
  localparam int SRC_SEL_BIT   = 6;
  localparam int POWER_SAVE_BIT = 6;
  localparam int ENABLE_BIT    = 7;

  localparam logic [5:0] CODE_ALL_ZERO = 6'h00;
  localparam logic [5:0] CODE_ALL_ONE  = 6'h3f;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  typedef logic [5:0] rtc_code_t;

  // reset contents before the one-time-programmable defaults are copied in
  localparam rtc_code_t RST_CODE = 6'h00;
  localparam logic      RST_BIT  = 1'b0;
endpackage

//--- src/rtc_regs.sv
// regulator three control registers: operating, alternate and ceiling
// Notes on behaviour
// - Reserved bits of the operating and ceiling registers read as zero and ignore writes.
// - The source-select bit picks the operating code at 0 and the alternate code at 1 for the output.
// - The alternate enable bit turns the regulator off at 0 and on at 1, and sequence-enabled variants set it at power-up.
// - The alternate low-power bit gives normal mode at 0 and power-save mode at 1.
// - Operating and alternate registers hold a six-bit voltage code in their low bits.
// - A write of a voltage code above the ceiling field is ignored.
// - A ceiling field other than all zeros or all ones makes the ceiling register read-only.
// - All three registers return to their defaults on power-on reset.
`timescale 1ns/1ns
module rtc_regs (
  // clock and power-on reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // one-time-programmable defaults
  input  wire rtc_pkg::rtc_code_t   otp_operating_code,
  input  wire rtc_pkg::rtc_code_t   otp_alternate_code,
  input  wire rtc_pkg::rtc_code_t   otp_ceiling_code,
  input  wire logic                 otp_enable,
  input  wire logic                 otp_seq_enable,
  // automatic power-up sequencer step for this regulator
  input  wire logic                 seq_start,
  // register access from the host serial interface
  input  wire logic [7:0]           host_addr,
  input  wire logic [7:0]           host_wdata,
  input  wire logic                 host_wr,
  input  wire logic                 host_rd,
  output logic      [7:0]           host_rdata,
  output logic                      host_rvalid,
  // regulator controls
  output rtc_pkg::rtc_code_t        vout_code,
  output logic                      reg_on,
  output logic                      reg_power_save,
  output logic                      defaults_loaded
);

  typedef struct packed {
    logic               loaded;
    logic               voltage_source_select;
    rtc_pkg::rtc_code_t op_code;
    logic               alt_enable;
    logic               power_save_bit;
    rtc_pkg::rtc_code_t alt_code;
    rtc_pkg::rtc_code_t ceil_code;
    logic [7:0]         rdata;
    logic               rvalid;
    rtc_pkg::rtc_code_t vout;
    logic               on;
    logic               psave;
  } rtc_state_s;

  rtc_state_s st;
  rtc_state_s next_st;

  logic               code_ok;
  logic               ceil_locked;
  rtc_pkg::rtc_code_t wr_code;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st     = st;
    wr_code     = host_wdata[rtc_pkg::CODE_MSB:0];
    code_ok     = (wr_code <= st.ceil_code);
    ceil_locked = (st.ceil_code != rtc_pkg::CODE_ALL_ZERO) &&
                  (st.ceil_code != rtc_pkg::CODE_ALL_ONE);
    next_st.rvalid = 1'b0;

    if (!st.loaded) begin
      // defaults copied once after reset release; the async reset first clears these fields to zero
      next_st.loaded     = 1'b1;
      next_st.op_code    = otp_operating_code;
      next_st.alt_code   = otp_alternate_code;
      next_st.ceil_code  = otp_ceiling_code;
      next_st.alt_enable = otp_enable;
    end else begin
      if (seq_start && otp_seq_enable) begin
        next_st.alt_enable = 1'b1;
      end
      if (host_wr) begin
        unique case (host_addr)
          rtc_pkg::ADDR_OPERATING: begin
            // whole write dropped when the code exceeds the ceiling
            if (code_ok) begin
              next_st.voltage_source_select = host_wdata[rtc_pkg::SRC_SEL_BIT];
              next_st.op_code               = wr_code;
            end
          end
          rtc_pkg::ADDR_ALTERNATE: begin
            if (code_ok) begin
              next_st.alt_enable     = host_wdata[rtc_pkg::ENABLE_BIT];
              next_st.power_save_bit = host_wdata[rtc_pkg::POWER_SAVE_BIT];
              next_st.alt_code       = wr_code;
            end
          end
          rtc_pkg::ADDR_CEILING: begin
            if (!ceil_locked) begin
              next_st.ceil_code = wr_code;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (host_rd) begin
      next_st.rvalid = 1'b1;
      unique case (host_addr)
        rtc_pkg::ADDR_OPERATING: next_st.rdata = {1'b0, st.voltage_source_select, st.op_code};
        rtc_pkg::ADDR_ALTERNATE: next_st.rdata = {st.alt_enable, st.power_save_bit, st.alt_code};
        rtc_pkg::ADDR_CEILING:   next_st.rdata = {2'b00, st.ceil_code};
        default:                 next_st.rdata = rtc_pkg::READ_ZERO;
      endcase
    end

    // outputs follow the stored fields one cycle later
    next_st.vout  = st.voltage_source_select ? st.alt_code : st.op_code;
    next_st.on    = st.alt_enable;
    next_st.psave = st.power_save_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st.loaded                <= 1'b0;
      st.voltage_source_select <= rtc_pkg::RST_BIT;
      st.op_code               <= rtc_pkg::RST_CODE;
      st.alt_enable            <= rtc_pkg::RST_BIT;
      st.power_save_bit        <= rtc_pkg::RST_BIT;
      st.alt_code              <= rtc_pkg::RST_CODE;
      st.ceil_code             <= rtc_pkg::RST_CODE;
      st.rdata                 <= rtc_pkg::READ_ZERO;
      st.rvalid                <= 1'b0;
      st.vout                  <= rtc_pkg::RST_CODE;
      st.on                    <= 1'b0;
      st.psave                 <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign host_rdata      = st.rdata;
  assign host_rvalid     = st.rvalid;
  assign vout_code       = st.vout;
  assign reg_on          = st.on;
  assign reg_power_save  = st.psave;
  assign defaults_loaded = st.loaded;

endmodule

//--- verif/rtc_regs_assertions.sv
// port-level checker for the regulator three control registers
`timescale 1ns/1ns
module rtc_regs_assertions (
  input wire logic sys_clk, rstn, otp_enable, otp_seq_enable, seq_start, host_wr, host_rd,
  input wire logic host_rvalid, reg_on, reg_power_save, defaults_loaded,
  input wire rtc_pkg::rtc_code_t otp_operating_code, otp_alternate_code, otp_ceiling_code, vout_code,
  input wire logic [7:0] host_addr, host_wdata, host_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] rd_addr;
  always_ff @(posedge sys_clk) rd_addr <= host_addr;
  ////////////////////////////////////////////////////////////////
  property p_rsv_op; host_rvalid && rd_addr == 8'h16 |-> !host_rdata[7]; endproperty
  a_rsv_op: assert property (p_rsv_op) else $error("op reserved set");
  property p_rsv_ceil; host_rvalid && rd_addr == 8'h18 |-> host_rdata[7:6] == 2'b00; endproperty
  a_rsv_ceil: assert property (p_rsv_ceil) else $error("ceil reserved set");
  // read data and outputs both show the register as it was before the read edge
  property p_vout; host_rvalid && rd_addr == 8'h16 && !host_rdata[6] |-> vout_code == host_rdata[5:0]; endproperty
  a_vout: assert property (p_vout) else $error("vout bad");
  property p_alt; host_rvalid && rd_addr == 8'h17 |-> {reg_on, reg_power_save} == host_rdata[7:6]; endproperty
  a_alt: assert property (p_alt) else $error("alt ctl bad");
  property p_load; $rose(defaults_loaded) |=> vout_code == otp_operating_code && reg_on == otp_enable; endproperty
  a_load: assert property (p_load) else $error("defaults bad");
  property p_seq; seq_start && otp_seq_enable && defaults_loaded && !host_wr |=> ##1 reg_on; endproperty
  a_seq: assert property (p_seq) else $error("seq on bad");
  property p_rvalid; host_rvalid == $past(host_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid bad");
  property p_unmap; host_rvalid && (rd_addr < 8'h16 || rd_addr > 8'h18) |-> host_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped bad");
  c_ceil: cover property (host_wr && host_addr == 8'h18);
  c_seq: cover property (seq_start && otp_seq_enable);
  c_alt: cover property (host_rd && host_addr == 8'h17);
endmodule

//--- verif/tb.sv
// random and corner-case bench for the regulator three registers
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0, rstn = 1'b0, otp_enable = 1'b1, otp_seq_enable = 1'b1, seq_start = 1'b0;
  logic host_wr = 1'b0, host_rd = 1'b0, host_rvalid, reg_on, reg_power_save, defaults_loaded;
  rtc_pkg::rtc_code_t otp_operating_code = 6'h39, otp_alternate_code = 6'h10, otp_ceiling_code = 6'h3f, vout_code;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, got, d, m_op, m_alt;
  int bad_count = 0, n_checks = 0, seed = 32'h57f0;
  rtc_regs rtc_regs_inst (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, dat);
    {host_wr, host_rd, host_addr, host_wdata} = {w, !w, a, dat};
    @(posedge sys_clk) #1;
    {host_wr, host_rd, got} = {2'b00, host_rdata};
    if (!w) chk("rvalid", {7'h00, host_rvalid}, 8'h01);
  endtask
  task automatic ctl;
    chk("vout", {2'b00, vout_code}, {2'b00, m_op[6] ? m_alt[5:0] : m_op[5:0]});
    chk("ctl", {6'h00, reg_on, reg_power_save}, {6'h00, m_alt[7:6]});
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rstn = 1'b1;
    for (int r = 0; r < 2; r++) begin
      repeat (2) @(posedge sys_clk) #1;
      {m_op, m_alt} = {2'b00, otp_operating_code, otp_enable, 1'b0, otp_alternate_code};
      ctl();
      chk("loaded", {7'h00, defaults_loaded}, 8'h01);
      acc(0, 8'h18, 8'h00);
      chk("ceil", got, {2'b00, otp_ceiling_code});
      if (r == 0) begin
        // open ceiling: every code is taken
        for (int i = 0; i < 40; i++) begin
          d = 8'($random(seed));
          acc(1, 8'h16 + i[0], d);
          if (i[0]) m_alt = d;
          else m_op = d & 8'h7f;
          acc(0, 8'h16 + i[0], 8'h00);
          chk("reg", got, i[0] ? m_alt : m_op);
          ctl();
        end
        acc(1, 8'h18, 8'hd5);
        acc(1, 8'h18, 8'h3f);
        acc(0, 8'h18, 8'h00);
        chk("lock", got, 8'h15);
        acc(1, 8'h16, 8'h16);
        acc(1, 8'h17, 8'hd5);
        acc(0, 8'h16, 8'h00);
        chk("op", got, m_op);
        acc(0, 8'h17, 8'h00);
        chk("alt", got, 8'hd5);
        acc(0, 8'h20, 8'h00);
        chk("unmapped", got, 8'h00);
        acc(1, 8'h17, 8'h00);
        seq_start = 1'b1;
        @(posedge sys_clk) #1 seq_start = 1'b0;
        @(posedge sys_clk) #1 m_alt = 8'h80;
        ctl();
        // one more edge so the sequencer assertion is not cut by the reset
        @(posedge sys_clk) #1;
        rstn = 1'b0;
        @(posedge sys_clk) #1 rstn = 1'b1;
      end
    end
    give_verdict;
  end
endmodule
bind rtc_regs rtc_regs_assertions rtc_regs_assertions_inst (.*);
